// ---- src/rtc_control.sv ----
// Control, weekday and periodic-event logic of the real-time clock.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
// How it works
// - Counting halts while run is clear.
// - Hour format clear counts hours 0 to 11.
// - Hour format set counts hours 0 to 23.
// - Soft reset clears everything but itself.
// - Timing clear raises events during busy period.
// - Timing set raises events after busy period.
// - Enable clear suppresses one-second events.
// - Friday 101, Saturday 110, 111 reserved.
// - Sunday 000 upward through Thursday 100.
module rtc_control
  import rtc_ctrl_pkg::*;
#(
  parameter int TICKS_PER_SECOND = TICKS_PER_SEC,  // Counting cycles of a second, before its busy period.
  parameter int BUSY_LENGTH      = BUSY_CYCLES     // Busy period cycles.
) (
  input  wire logic              sys_clk,      // System clock, 200 MHz.
  input  wire logic              reset_n,      // Async reset, active low.
  input  wire logic [ADDR_W-1:0] address,      // Avalon byte address.
  input  wire logic              read,         // Avalon read request.
  input  wire logic              write,        // Avalon write request.
  input  wire logic [DATA_W-1:0] writedata,    // Avalon write data.
  input  wire logic [3:0]        byteenable,   // Avalon byte lanes.
  output logic      [DATA_W-1:0] readdata,     // Avalon read data.
  output logic                   waitrequest,  // Avalon stall.
  output logic                   irq           // Level interrupt.
);

  // ==========================================================================
  // Declarations.
  logic             ack;          // Second cycle of a bus access.
  logic             wrAccept;     // Write takes effect this cycle.
  logic             run;          // Counting enabled.
  logic             hour24;       // 24-hour mode.
  logic             softReset;    // Soft reset held.
  logic             irqTiming;    // Events after the busy period.
  logic             oneSecEn;     // One-second event enable.
  logic             running;      // Counting and not in soft reset.
  logic             busy;         // Busy period in progress.
  logic             busyStart;    // First busy cycle.
  logic             busyEnd;      // First cycle after busy.
  logic [5:0]       sec;          // Seconds count.
  logic [5:0]       minute;       // Minutes count.
  logic [4:0]       hour;         // Hours count.
  weekday_t         weekday;      // Day of the week.
  logic [4:0]       hourLast;     // Last hour of the current mode.
  logic             secWrap;      // Seconds roll over.
  logic             minWrap;      // Minutes roll over.
  logic             hourWrap;     // Hours roll over.
  logic             stepNow;      // Counters advance this cycle.
  logic             hourStep;     // Hours advance this cycle.
  logic             dayStep;      // Weekday advances this cycle.
  logic             evtMoment;    // Periodic events are raised now.
  logic             secSet;       // Second event raised now.
  logic             timeWrite;    // Software writes the time word.
  logic             ctrlOneWrite; // Software writes control one.
  logic [EVT_W-1:0] evtSet;       // Events raised now.
  logic [EVT_W-1:0] evtClear;     // Events cleared by software.
  logic [EVT_W-1:0] status;       // Sticky event bits.
  logic [EVT_W-1:0] next_status;  // Status for the next cycle.
  logic [EVT_W-1:0] mask;         // Event mask.
  logic [31:0]      ctrlOneView;  // Read image of control one.
  logic [31:0]      ctrlTwoView;  // Read image of control two.
  logic [31:0]      timeView;     // Read image of the time word.

  // ==========================================================================
  // Busy period timer; soft reset counts as one of its control circuits.
  rtc_tick_timer #(
    .TICKS (TICKS_PER_SECOND),
    .BUSY  (BUSY_LENGTH)
  ) u_tick_timer (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .clear     (softReset),
    .enable    (running),
    .busy      (busy),
    .busyStart (busyStart),
    .busyEnd   (busyEnd)
  );

  // ==========================================================================
  // Avalon slave: every access waits exactly one cycle, then completes.
  assign waitrequest  = (read || write) && !ack;
  assign wrAccept     = write && ack;
  assign ctrlOneWrite = wrAccept && address == CTRL_ONE_ADDR && byteenable[0];
  assign timeWrite    = wrAccept && address == TIME_ADDR && !softReset;

  // The ack flop drops after each answer, so requests cannot overlap.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end

  // ==========================================================================
  // Control one; while soft reset is held only the soft reset bit listens.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run       <= BIT_RESET;
      hour24    <= BIT_RESET;
      softReset <= BIT_RESET;
      irqTiming <= BIT_RESET;
    end else begin
      if (ctrlOneWrite) begin
        softReset <= writedata[SOFT_RESET_BIT];
      end
      if (softReset) begin
        run       <= BIT_RESET;
        hour24    <= BIT_RESET;
        irqTiming <= BIT_RESET;
      end else if (ctrlOneWrite) begin
        run       <= writedata[RUN_BIT];
        hour24    <= writedata[HOUR24_BIT];
        irqTiming <= writedata[IRQ_TIMING_BIT];
      end
    end
  end

  // Control two holds only the one-second event enable.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oneSecEn <= BIT_RESET;
    end else if (softReset) begin
      oneSecEn <= BIT_RESET;
    end else if (wrAccept && address == CTRL_TWO_ADDR && byteenable[0]) begin
      oneSecEn <= writedata[ONE_SEC_IRQ_BIT];
    end
  end

  // ==========================================================================
  // Time counting; carries are judged on the values of the ending second.
  // counting gated by run
  assign running  = run && !softReset;
  assign stepNow  = busyEnd && running;
  assign hourLast = hour24 ? HOUR24_LAST : HOUR12_LAST;
  assign secWrap  = (sec >= SEC_LAST);
  assign minWrap  = secWrap && (minute >= MIN_LAST);
  assign hourWrap = minWrap && (hour >= hourLast);
  assign hourStep = stepNow && minWrap;
  assign dayStep  = stepNow && hourWrap;

  // A software write beats a step in the same cycle, since it is newer.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec     <= '0;
      minute  <= '0;
      hour    <= '0;
      weekday <= SUNDAY;
    end else if (softReset) begin
      sec     <= '0;
      minute  <= '0;
      hour    <= '0;
      weekday <= SUNDAY;
    end else if (timeWrite) begin
      if (byteenable[0]) sec <= writedata[SEC_LSB +: 6];
      if (byteenable[1]) minute <= writedata[MIN_LSB +: 6];
      if (byteenable[2]) hour <= writedata[HOUR_LSB +: 5];
      if (byteenable[3] && writedata[DAY_LSB +: 3] != RESERVED_DAY) begin
        weekday <= weekday_t'(writedata[DAY_LSB +: 3]);
      end
    end else if (stepNow) begin
      sec <= secWrap ? '0 : sec + 6'h01;
      if (secWrap) minute <= (minute >= MIN_LAST) ? '0 : minute + 6'h01;
      if (minWrap) hour <= (hour >= hourLast) ? '0 : hour + 5'h01;
      if (hourWrap) begin
        weekday <= (weekday >= SATURDAY) ? SUNDAY
                                         : weekday_t'(weekday + 3'h1);
      end
    end
  end

  // ==========================================================================
  // Periodic events and the sticky status.
  // during busy period, or right after it when irqTiming is set
  assign evtMoment = running && (irqTiming ? busyEnd : busyStart);
  assign secSet = evtMoment && oneSecEn;

  always_comb begin
    evtSet           = '0;
    evtSet[SEC_EVT]  = secSet;
    evtSet[MIN_EVT]  = evtMoment && secWrap;
    evtSet[HOUR_EVT] = evtMoment && minWrap;
    evtSet[DAY_EVT]  = evtMoment && hourWrap;
    evtClear         = '0;
    if (wrAccept && address == IRQ_STATUS_ADDR && byteenable[0]) begin
      evtClear = writedata[EVT_W-1:0];
    end
    // A new event wins over a clear written in the same cycle.
    next_status = (status & ~evtClear) | evtSet;
  end

  // Status clears by writing ones; soft reset empties it.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= EVT_RESET;
    end else if (softReset) begin
      status <= EVT_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Mask selects which events reach the interrupt line.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask <= EVT_RESET;
    end else if (softReset) begin
      mask <= EVT_RESET;
    end else if (wrAccept && address == IRQ_MASK_ADDR && byteenable[0]) begin
      mask <= writedata[EVT_W-1:0];
    end
  end

  // Combinational so an unmasked event shows in the cycle it is stored.
  assign irq = |(status & mask);

  // ==========================================================================
  // Read images; unused and reserved bits read as zero.
  always_comb begin
    ctrlOneView                  = '0;
    ctrlOneView[RUN_BIT]         = run;
    ctrlOneView[HOUR24_BIT]      = hour24;
    ctrlOneView[SOFT_RESET_BIT]  = softReset;
    ctrlOneView[IRQ_TIMING_BIT]  = irqTiming;
    ctrlTwoView                  = '0;
    ctrlTwoView[ONE_SEC_IRQ_BIT] = oneSecEn;
    timeView                     = '0;
    timeView[SEC_LSB +: 6]       = sec;
    timeView[MIN_LSB +: 6]       = minute;
    timeView[HOUR_LSB +: 5]      = hour;
    timeView[DAY_LSB +: 3]       = weekday;
  end

  // Read data is loaded in the waiting cycle and stands while ack is high.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= '0;
    end else if (read && !ack) begin
      unique case (address)
        CTRL_ONE_ADDR:   readdata <= ctrlOneView;
        CTRL_TWO_ADDR:   readdata <= ctrlTwoView;
        IRQ_STATUS_ADDR: readdata <= {28'h0000000, status};
        IRQ_MASK_ADDR:   readdata <= {28'h0000000, mask};
        TIME_ADDR:       readdata <= timeView;
        default:         readdata <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Checks.
  sequence earlyEventS;
    busyStart && running && !irqTiming && oneSecEn;
  endsequence

  sequence lateEventS;
    busyEnd && running && irqTiming && oneSecEn;
  endsequence

  sequence secStoredS;
    ##1 status[SEC_EVT];
  endsequence

  property haltWhileStopped_p;
    @(posedge sys_clk) disable iff (!reset_n)
    (!run && !timeWrite && !softReset)
      |=> $stable({sec, minute, hour, weekday});
  endproperty

  halt_while_stopped_a: assert property (haltWhileStopped_p)
    else $error("Time moved while counting was stopped.");

  count_while_run_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (stepNow && !timeWrite) |=> sec != $past(sec))
    else $error("Seconds did not advance at the end of a busy period.");

  hour_twelve_wrap_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (hourStep && !hour24 && hour == HOUR12_LAST && !timeWrite)
      |=> hour == 5'h00)
    else $error("Twelve-hour count did not wrap after eleven.");

  hour_day_wrap_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (hourStep && hour24 && hour == HOUR12_LAST && !timeWrite)
      |=> hour == 5'h0c ##0 (hour24 throughout (hour != 5'h00)[*1]))
    else $error("Twenty-four-hour count wrapped too early.");

  hour_late_wrap_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (hourStep && hour24 && hour == HOUR24_LAST && !timeWrite)
      |=> hour == 5'h00)
    else $error("Twenty-four-hour count did not wrap after 23.");

  soft_reset_clear_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (softReset && !ctrlOneWrite) |=> softReset && !run && !hour24
      && !irqTiming && !oneSecEn && status == EVT_RESET
      && mask == EVT_RESET && sec == 6'h00 && !irq)
    else $error("Soft reset left state uncleared or dropped itself.");

  early_event_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    earlyEventS |-> busy ##0 secStoredS)
    else $error("Second event missing during the busy period.");

  late_event_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    lateEventS |-> !busy ##0 secStoredS)
    else $error("Second event missing right after the busy period.");

  no_busy_event_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (busy && irqTiming) |-> evtSet == EVT_RESET)
    else $error("Event raised inside busy period in late mode.");

  second_disabled_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (!oneSecEn && !softReset) |=> !$rose(status[SEC_EVT]))
    else $error("Second event stored while its enable was clear.");

  reserved_day_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    weekday != RESERVED_DAY)
    else $error("Weekday holds the reserved code.");

  friday_next_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dayStep && weekday == FRIDAY && !timeWrite) |=> weekday == SATURDAY)
    else $error("Friday was not followed by Saturday.");

  weekday_order_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (dayStep && weekday == SATURDAY && !timeWrite) |=> weekday == SUNDAY)
    else $error("Saturday was not followed by Sunday.");

  second_each_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (evtMoment && oneSecEn) |-> secSet ##1 status[SEC_EVT] ##0 !evtMoment)
    else $error("One-second event missing or raised twice.");

endmodule : rtc_control

// ---- src/rtc_ctrl_pkg.sv ----
// Shared constants and types of the real-time clock control block.
package rtc_ctrl_pkg;

  // ==========================================================================
  // Bus geometry.
  localparam int ADDR_W = 18;  // Byte address width of the register slave.
  localparam int DATA_W = 32;  // Data width of the register slave.

  // ==========================================================================
  // Register indexes; the byte address is four times the index.
  localparam logic [15:0] CTRL_ONE_INDEX   = 16'hf06c;  // Run and mode bits.
  localparam logic [15:0] CTRL_TWO_INDEX   = 16'hf06d;  // Second irq enable.
  localparam logic [15:0] IRQ_STATUS_INDEX = 16'hf070;  // Sticky events.
  localparam logic [15:0] IRQ_MASK_INDEX   = 16'hf071;  // Event mask.
  localparam logic [15:0] TIME_INDEX       = 16'hf072;  // Time of day.
  localparam logic [ADDR_W-1:0] CTRL_ONE_ADDR   = {CTRL_ONE_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] CTRL_TWO_ADDR   = {CTRL_TWO_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {IRQ_STATUS_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = {IRQ_MASK_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] TIME_ADDR       = {TIME_INDEX, 2'h0};

  // ==========================================================================
  // Field positions.
  localparam int RUN_BIT         = 7;  // Counting runs while set.
  localparam int HOUR24_BIT      = 6;  // 24-hour counting while set.
  localparam int SOFT_RESET_BIT  = 4;  // Soft reset held while set.
  localparam int IRQ_TIMING_BIT  = 3;  // Events after the busy period.
  localparam int ONE_SEC_IRQ_BIT = 2;  // One-second event enable.
  localparam int SEC_EVT         = 0;  // Status bit of the second event.
  localparam int MIN_EVT         = 1;  // Status bit of the minute event.
  localparam int HOUR_EVT        = 2;  // Status bit of the hour event.
  localparam int DAY_EVT         = 3;  // Status bit of the weekday event.
  localparam int EVT_W           = 4;  // Number of event bits.
  localparam int SEC_LSB         = 0;  // Seconds field of the time word.
  localparam int MIN_LSB         = 8;  // Minutes field of the time word.
  localparam int HOUR_LSB        = 16; // Hours field of the time word.
  localparam int DAY_LSB         = 24; // Weekday field of the time word.

  // ==========================================================================
  // Values after reset and counting limits.
  localparam logic [EVT_W-1:0] EVT_RESET   = 4'h0;   // Status and mask.
  localparam logic             BIT_RESET   = 1'b0;   // Every control bit.
  localparam logic [5:0]       SEC_LAST    = 6'h3b;  // Last second, 59.
  localparam logic [5:0]       MIN_LAST    = 6'h3b;  // Last minute, 59.
  localparam logic [4:0]       HOUR12_LAST = 5'h0b;  // Last hour, 11.
  localparam logic [4:0]       HOUR24_LAST = 5'h17;  // Last hour, 23.

  // ==========================================================================
  // Timing.
  localparam longint SECOND_NS     = 64'd1_000_000_000; // One second.
  localparam int     CLK_PERIOD_NS = 5;                 // sys_clk period.
  localparam int     BUSY_NS       = 50;                // Busy period length.
  localparam int     TICKS_PER_SEC = int'(SECOND_NS / CLK_PERIOD_NS);
  localparam int     BUSY_CYCLES   =
    (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;  // Rounded up.

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    SUNDAY       = 3'b000,
    MONDAY       = 3'b001,
    TUESDAY      = 3'b010,
    WEDNESDAY    = 3'b011,
    THURSDAY     = 3'b100,
    FRIDAY       = 3'b101,
    SATURDAY     = 3'b110,
    RESERVED_DAY = 3'b111
  } weekday_t;

  typedef enum logic [0:0] {
    PH_COUNT = 1'b0,
    PH_BUSY  = 1'b1
  } phase_t;

endpackage : rtc_ctrl_pkg

// ---- src/rtc_tick_timer.sv ----
// One-second prescaler that frames each counter busy period.
`timescale 1ns/10ps
module rtc_tick_timer
  import rtc_ctrl_pkg::*;
#(
  parameter int TICKS = TICKS_PER_SEC,  // Counting cycles of one second, before its busy period.
  parameter int BUSY  = BUSY_CYCLES     // Cycles of the busy period.
) (
  input  wire logic sys_clk,    // System clock.
  input  wire logic reset_n,    // Asynchronous reset, active low.
  input  wire logic clear,      // Synchronous clear from soft reset.
  input  wire logic enable,     // Time is counting.
  output logic      busy,       // Busy period in progress.
  output logic      busyStart,  // First cycle of a busy period.
  output logic      busyEnd     // First cycle after a busy period.
);

  // ==========================================================================
  // Counters.
  localparam int CW = $clog2(TICKS + 1);  // Width of the second counter.
  localparam int BW = $clog2(BUSY + 1);   // Width of the busy counter.

  phase_t        phase;      // Counting or busy.
  logic [CW-1:0] tickCount;  // Cycles into the current second.
  logic [BW-1:0] busyCount;  // Cycles into the busy period.
  logic          tickDone;   // Last cycle before the busy period.
  logic          busyDone;   // Last cycle of the busy period.

  assign tickDone = (tickCount == CW'(TICKS - 1));
  assign busyDone = (busyCount == BW'(BUSY - 1));
  assign busy     = (phase == PH_BUSY);

  // Phase advances only while enabled, so a stop freezes it mid-period.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_COUNT;
    end else if (clear) begin
      phase <= PH_COUNT;
    end else if (enable) begin
      unique case (phase)
        PH_COUNT: if (tickDone) phase <= PH_BUSY;
        PH_BUSY:  if (busyDone) phase <= PH_COUNT;
      endcase
    end
  end

  // Cycle counters; each rests at zero outside its own phase.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCount <= '0;
      busyCount <= '0;
    end else if (clear) begin
      tickCount <= '0;
      busyCount <= '0;
    end else if (enable) begin
      if (phase == PH_COUNT) begin
        tickCount <= tickDone ? '0 : tickCount + CW'(1);
      end else begin
        busyCount <= busyDone ? '0 : busyCount + BW'(1);
      end
    end
  end

  // Edge pulses, registered so they line up with the phase change.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busyStart <= 1'b0;
      busyEnd   <= 1'b0;
    end else begin
      busyStart <= enable && !clear && phase == PH_COUNT && tickDone;
      busyEnd   <= enable && !clear && phase == PH_BUSY && busyDone;
    end
  end

endmodule : rtc_tick_timer

// ---- test/testbench.sv ----
// Self-checking testbench of the real-time clock control block.
`timescale 1ns/10ps
module testbench;
  import rtc_ctrl_pkg::*;
  // ==========================================================================
  // Stimulus and observation signals.
  localparam int TK = 20;  // Short second keeps the run brief.
  localparam int BL = 3;   // Short busy period.
  logic              sys_clk;      // Bench clock.
  logic              reset_n;      // Reset, active low.
  logic [ADDR_W-1:0] address;      // Bus address.
  logic              read;         // Bus read.
  logic              write;        // Bus write.
  logic [DATA_W-1:0] writedata;    // Bus write data.
  logic [3:0]        byteenable;   // All lanes used.
  logic [DATA_W-1:0] readdata;     // Bus read data.
  logic              waitrequest;  // Bus stall.
  logic              irq;          // Level interrupt.
  int                failures;     // Mismatch count.
  int                total_checks; // Comparison count.
  int                n0;           // Cycles to event, early timing.
  int                n1;           // Cycles to event, late timing.
  logic [DATA_W-1:0] q;            // Read result.
  logic [DATA_W-1:0] t1;           // Frozen time sample.
  rtc_control #(.TICKS_PER_SECOND(TK), .BUSY_LENGTH(BL)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
  // ==========================================================================
  // Clock, and a watchdog that cuts a hang short.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    failures++;
    summarize();
  end
  // ==========================================================================
  // Helpers: time word, compare, one bus access.
  function automatic logic [31:0] tw(int d, int h, int m, int s);
    return {5'h0, d[2:0], 3'h0, h[4:0], 2'h0, m[5:0], 2'h0, s[5:0]};
  endfunction : tw
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // The request is held until waitrequest is low at a rising edge; sampling
  // it on the falling edge avoids a race with the slave's own update.
  task automatic access(input logic we, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [31:0] r);
    int k;
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    write <= we;
    read <= ~we;
    for (k = 0; k < 50; k++) begin
      @(negedge sys_clk);
      if (waitrequest === 1'b0) break;
    end
    if (k == 50) failures++;
    @(posedge sys_clk);
    r = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : access
  // Fresh start through soft reset, then run until the first event.
  task automatic run_one(logic [7:0] c1, logic [7:0] c2, logic [31:0] t,
                         logic [31:0] et, logic [3:0] es, output int n);
    access(1'b1, CTRL_ONE_ADDR, 32'h10, q);
    access(1'b1, CTRL_ONE_ADDR, 32'h0, q);
    access(1'b1, CTRL_TWO_ADDR, {24'h0, c2}, q);
    access(1'b1, IRQ_MASK_ADDR, 32'hf, q);
    access(1'b1, TIME_ADDR, t, q);
    access(1'b1, CTRL_ONE_ADDR, {24'h0, c1}, q);
    // Looked at on the falling edge, where the level has settled.
    for (n = 0; n < 200 && irq !== 1'b1; n++) @(negedge sys_clk);
    if (n == 200) failures++;
    repeat (10) @(posedge sys_clk);
    access(1'b0, TIME_ADDR, 32'h0, q);
    check("time", et, q);
    access(1'b0, IRQ_STATUS_ADDR, 32'h0, q);
    check("status", {28'h0, es}, q);
  endtask : run_one
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // ==========================================================================
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'hf;
    failures = 0;
    total_checks = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    access(1'b0, 18'h00010, 32'h0, q);
    check("unmapped", 32'h0, q);
    run_one(8'h80, 8'h04, tw(6, 11, 59, 59), tw(0, 0, 0, 0), 4'hf, n0);
    run_one(8'h88, 8'h04, tw(6, 11, 59, 59), tw(0, 0, 0, 0), 4'hf, n1);
    check("timing", BL, n1 - n0);
    run_one(8'hc0, 8'h00, tw(5, 11, 59, 59), tw(5, 12, 0, 0), 4'h6, n0);
    run_one(8'hc0, 8'h00, tw(5, 23, 59, 59), tw(6, 0, 0, 0), 4'he, n0);
    access(1'b1, IRQ_STATUS_ADDR, 32'hf, q);
    access(1'b0, IRQ_STATUS_ADDR, 32'h0, q);
    check("cleared", 32'h0, q);
    check("irq", 32'h0, {31'h0, irq});
    // One full second with the enable set must store one second event.
    access(1'b1, CTRL_TWO_ADDR, 32'h4, q);
    repeat (TK + BL) @(posedge sys_clk);
    access(1'b0, IRQ_STATUS_ADDR, 32'h0, q);
    check("second event", 32'h1, q);
    check("irq set", 32'h1, {31'h0, irq});
    access(1'b1, CTRL_ONE_ADDR, 32'h40, q);
    access(1'b0, TIME_ADDR, 32'h0, t1);
    repeat (60) @(posedge sys_clk);
    access(1'b0, TIME_ADDR, 32'h0, q);
    check("frozen", t1, q);
    access(1'b1, TIME_ADDR, tw(7, 1, 1, 1), q);
    access(1'b0, TIME_ADDR, 32'h0, q);
    check("reserved day", {t1[31:24], 24'h010101}, q);
    access(1'b1, CTRL_ONE_ADDR, 32'hd8, q);
    access(1'b1, IRQ_MASK_ADDR, 32'hf, q);
    access(1'b0, CTRL_ONE_ADDR, 32'h0, q);
    check("soft reset", 32'h10, q);
    access(1'b0, IRQ_MASK_ADDR, 32'h0, q);
    check("mask held", 32'h0, q);
    access(1'b0, TIME_ADDR, 32'h0, q);
    check("time held", tw(0, 0, 0, 0), q);
    access(1'b1, CTRL_ONE_ADDR, 32'h0, q);
    summarize();
  end
endmodule : testbench
